/* File: inc/acs_consts.svh */
// Constants of the conversion sequencer
// Notes on behaviour
// [RULE_01] Software disables converter, then calibrates before converting
// [RULE_02] Calibration blocks conversions; request self-clears when done
// [RULE_03] Calibration factor readable in data bits 6:0
// [RULE_04] Single mode: one pass per start
// [RULE_05] Continuous mode: passes repeat without new start
// [RULE_06] Start by software bit or hardware trigger
// [RULE_07] Each conversion stores data, sets done flag, irq; code keeps old data while done flag is set and overrun_keep_new is clear
// [RULE_08] Sequence end sets sequence flag, irq when enabled
// [RULE_09] Discontinuous: one channel per trigger, advancing
// [RULE_10] Normal: every sequence channel per trigger, in order
// [RULE_11] Resolution twelve, ten, eight or six bits
// [RULE_12] Result left or right aligned in 16 bits
// [RULE_13] Nineteen channels: sixteen pins, three internal
// [RULE_14] Auto shutdown powers core only while converting; code also powers it during calibration
// [RULE_15] Irq sources: conv, seq, sampling, ready, overrun, watchdog
// [RULE_16] Triggers from external pin and timers
// [RULE_17] Edge field: off, rising, falling, both
// [RULE_18] Conversion with done flag still set raises overrun
// [RULE_19] Discontinuous sequence flag only after final channel
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
`define ACS_NCH 19
`define ACS_CHW 5
`define ACS_NTRG 8
`define ACS_EXT_PIN_SEL 3'h7
`define ACS_EDGE_OFF 2'h0
`define ACS_EDGE_RISE 2'h1
`define ACS_EDGE_FALL 2'h2
`define ACS_EDGE_BOTH 2'h3
`define ACS_RES_12 2'h0
`define ACS_RES_10 2'h1
`define ACS_RES_8 2'h2
`define ACS_RES_6 2'h3
`define ACS_CAL_LSB 0
`define ACS_CAL_W 7
`define ACS_ZERO16 16'h0000
`endif

/* File: inc/acs_pkg.sv */
// Types of the conversion sequencer
`include "acs_consts.svh"
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_IDLE = 3'h0,
    ACS_WAKE = 3'h1,
    ACS_CONV = 3'h3,
    ACS_CAL = 3'h2
  } acs_state_t;
  typedef struct packed {
    logic continuous_select;
    logic discontinuous_en;
    logic left_align;
    logic [1:0] resolution;
    logic auto_off;
    logic overrun_keep_new;
    logic [2:0] trigger_source;
    logic [1:0] trigger_edge_select;
  } acs_cfg_t;
  typedef struct packed {
    logic conv_done_irq_en;
    logic seq_done_irq_en;
    logic smp_done_irq_en;
    logic ready_irq_en;
    logic overrun_irq_en;
    logic watchdog_irq_en;
  } acs_ien_t;
  typedef struct packed {
    logic conv_done_flag;
    logic seq_done_flag;
    logic smp_done_flag;
    logic ready_flag;
    logic overrun_flag;
    logic watchdog_flag;
  } acs_flags_t;
  typedef struct packed {
    acs_state_t st;
    logic [`ACS_CHW-1:0] slot;
    logic [`ACS_CHW-1:0] chan;
    logic cal_req;
    logic [15:0] data;
    acs_flags_t flg;
    logic [`ACS_NTRG-1:0] trg_s1;
    logic [`ACS_NTRG-1:0] trg_s2;
    logic [`ACS_NTRG-1:0] trg_s3;
    logic core_pwr;
    logic core_start;
    logic core_cal;
    logic irq;
  } acs_state_all_t;
endpackage

/* File: core/acs_sequencer.sv */
// Conversion sequencer control logic
`include "acs_consts.svh"
module acs_sequencer import acs_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CONVERTER_ENABLE,
  input wire logic CAL_START,
  input wire logic CONV_START,
  input wire logic CONV_STOP,
  input wire acs_cfg_t CFG,
  input wire acs_ien_t IEN,
  input wire logic [`ACS_NCH-1:0] SEQ_MASK,
  input wire acs_flags_t FLAG_CLR,
  input wire logic DATA_READ,
  input wire logic [`ACS_NTRG-1:0] TRIG_IN,
  input wire logic CORE_READY,
  input wire logic CORE_SMP_DONE,
  input wire logic CORE_DONE,
  input wire logic [11:0] CORE_RESULT,
  input wire logic [`ACS_CAL_W-1:0] CORE_CAL_FACTOR,
  input wire logic CORE_WATCHDOG,
  output logic CORE_POWER,
  output logic CORE_START,
  output logic CORE_CAL,
  output logic [`ACS_CHW-1:0] CORE_CHANNEL,
  output logic [1:0] CORE_RESOLUTION,
  output logic CAL_BUSY,
  output logic CONV_BUSY,
  output logic [15:0] DATA,
  output acs_flags_t FLAGS,
  output logic IRQ
);
  acs_state_all_t q, d;

  // Next enabled sequence slot at or above a position
  function automatic logic [`ACS_CHW:0] next_slot(input logic [`ACS_NCH-1:0] m,
                                                  input logic [`ACS_CHW-1:0] from);
    logic [`ACS_CHW:0] r;
    r = {1'b1, {`ACS_CHW{1'b0}}};
    for (int i = `ACS_NCH - 1; i >= 0; i--) begin
      if (m[i] && i >= int'(from)) begin
        r = {1'b0, 5'(i)};
      end
    end
    return r;
  endfunction

  // Scale 12-bit result to resolution and align it
  function automatic logic [15:0] place(input logic [11:0] r, input logic [1:0] res,
                                        input logic left);
    logic [11:0] v;
    logic [15:0] o;
    v = r;
    o = `ACS_ZERO16;
    unique case (res)
      `ACS_RES_12: v = r;
      `ACS_RES_10: v = {2'h0, r[11:2]};
      `ACS_RES_8: v = {4'h0, r[11:4]};
      `ACS_RES_6: v = {6'h0, r[11:6]};
    endcase
    if (!left) begin
      o = {4'h0, v};
    end else begin
      unique case (res)
        `ACS_RES_12: o = {v, 4'h0};
        `ACS_RES_10: o = {v[9:0], 6'h00};
        `ACS_RES_8: o = {v[7:0], 8'h00};
        `ACS_RES_6: o = {v[5:0], 10'h000};
      endcase
    end
    return o;
  endfunction

  logic [`ACS_CHW:0] ns_first, ns_after;
  logic trg_rise, trg_fall, hw_trig, start_req, conv_evt, pass_end;
  logic [`ACS_CHW-1:0] slot_inc;

  always_comb begin
    d = q;
    slot_inc = q.slot + 5'h01;
    ns_first = next_slot(SEQ_MASK, 5'h00);
    ns_after = next_slot(SEQ_MASK, slot_inc);
    d.trg_s1 = TRIG_IN;
    d.trg_s2 = q.trg_s1;
    d.trg_s3 = q.trg_s2;
    // Timer and pin sources share one selector; see [RULE_16]
    trg_rise = q.trg_s2[CFG.trigger_source] && !q.trg_s3[CFG.trigger_source];
    trg_fall = !q.trg_s2[CFG.trigger_source] && q.trg_s3[CFG.trigger_source];
    unique case (CFG.trigger_edge_select) // see [RULE_17]
      `ACS_EDGE_OFF: hw_trig = 1'b0;
      `ACS_EDGE_RISE: hw_trig = trg_rise;
      `ACS_EDGE_FALL: hw_trig = trg_fall;
      `ACS_EDGE_BOTH: hw_trig = trg_rise || trg_fall;
    endcase
    start_req = (CONV_START || hw_trig) && CONVERTER_ENABLE && !ns_first[`ACS_CHW]; // see [RULE_06]
    conv_evt = (q.st == ACS_CONV) && CORE_DONE;
    pass_end = ns_after[`ACS_CHW];
    d.core_start = 1'b0;
    d.core_cal = 1'b0;
    // Flag clears first so a same-cycle set wins
    d.flg = q.flg & ~FLAG_CLR;
    if (DATA_READ) begin
      d.flg.conv_done_flag = 1'b0;
    end
    if (CORE_SMP_DONE && q.st == ACS_CONV) begin
      d.flg.smp_done_flag = 1'b1; // see [RULE_15]
    end
    if (CORE_WATCHDOG) begin
      d.flg.watchdog_flag = 1'b1; // see [RULE_15]
    end
    if (CORE_READY && !q.core_pwr) begin
      d.flg.ready_flag = 1'b1; // see [RULE_15]
    end
    unique case (q.st)
      ACS_IDLE: begin
        // Calibration only accepted with converter disabled; see [RULE_01]
        if (CAL_START && !CONVERTER_ENABLE) begin
          d.cal_req = 1'b1;
          d.core_cal = 1'b1;
          d.st = ACS_CAL;
        end else if (start_req) begin
          d.slot = (q.slot == 5'h00 || !CFG.discontinuous_en) ? ns_first[`ACS_CHW-1:0] : q.slot;
          d.st = ACS_WAKE;
        end
      end
      ACS_CAL: begin
        // Triggers ignored here; see [RULE_02]
        if (CORE_DONE) begin
          d.cal_req = 1'b0; // see [RULE_02]
          d.data = {9'h000, CORE_CAL_FACTOR}; // see [RULE_03]
          d.st = ACS_IDLE;
        end
      end
      ACS_WAKE: begin
        d.core_pwr = 1'b1; // see [RULE_14]
        if (CORE_READY) begin
          d.chan = q.slot; // see [RULE_13]
          d.core_start = 1'b1;
          d.st = ACS_CONV;
        end
      end
      ACS_CONV: begin
        if (CONV_STOP || !CONVERTER_ENABLE) begin
          d.st = ACS_IDLE;
          d.slot = 5'h00;
        end else if (CORE_DONE) begin
          if (q.flg.conv_done_flag && !DATA_READ && !FLAG_CLR.conv_done_flag) begin
            d.flg.overrun_flag = 1'b1; // see [RULE_18]
          end
          if (!(q.flg.conv_done_flag && !CFG.overrun_keep_new)) begin
            d.data = place(CORE_RESULT, CFG.resolution, CFG.left_align); // see [RULE_07], [RULE_11], [RULE_12]
          end
          d.flg.conv_done_flag = 1'b1; // see [RULE_07]
          if (pass_end) begin
            d.flg.seq_done_flag = 1'b1; // see [RULE_08], [RULE_19]
            d.slot = ns_first[`ACS_CHW-1:0];
          end else begin
            d.slot = ns_after[`ACS_CHW-1:0]; // see [RULE_10]
          end
          if (CFG.discontinuous_en) begin
            d.st = ACS_IDLE; // see [RULE_09]
            if (pass_end) begin
              d.slot = 5'h00;
            end
          end else if (!pass_end) begin
            d.chan = ns_after[`ACS_CHW-1:0]; // see [RULE_10]
            d.core_start = 1'b1;
          end else if (CFG.continuous_select) begin
            d.chan = ns_first[`ACS_CHW-1:0]; // see [RULE_05]
            d.core_start = 1'b1;
          end else begin
            d.st = ACS_IDLE; // see [RULE_04]
            d.slot = 5'h00;
          end
        end
      end
      default: d.st = ACS_IDLE;
    endcase
    if (d.st == ACS_IDLE && CFG.auto_off) begin
      d.core_pwr = 1'b0; // see [RULE_14]
    end else if (d.st == ACS_CAL || (!CFG.auto_off && CONVERTER_ENABLE)) begin
      d.core_pwr = 1'b1;
    end
    d.irq = (d.flg.conv_done_flag && IEN.conv_done_irq_en)
      || (d.flg.seq_done_flag && IEN.seq_done_irq_en)
      || (d.flg.smp_done_flag && IEN.smp_done_irq_en)
      || (d.flg.ready_flag && IEN.ready_irq_en)
      || (d.flg.overrun_flag && IEN.overrun_irq_en)
      || (d.flg.watchdog_flag && IEN.watchdog_irq_en); // see [RULE_07], [RULE_08], [RULE_15], [RULE_18]
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign CORE_POWER = q.core_pwr;
  assign CORE_START = q.core_start;
  assign CORE_CAL = q.core_cal;
  assign CORE_CHANNEL = q.chan;
  assign CORE_RESOLUTION = CFG.resolution;
  assign CAL_BUSY = q.cal_req;
  assign CONV_BUSY = (q.st == ACS_WAKE) || (q.st == ACS_CONV);
  assign DATA = q.data;
  assign FLAGS = q.flg;
  assign IRQ = q.irq;
endmodule // acs_sequencer

/* File: tb/acs_sva.sv */
// Port assertions of the conversion sequencer
`include "acs_consts.svh"
module acs_sva import acs_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CONV_STOP,
  input wire acs_cfg_t CFG,
  input wire acs_ien_t IEN,
  input wire logic [`ACS_NCH-1:0] SEQ_MASK,
  input wire logic CORE_DONE,
  input wire logic [`ACS_CAL_W-1:0] CORE_CAL_FACTOR,
  input wire logic CORE_START,
  input wire logic [`ACS_CHW-1:0] CORE_CHANNEL,
  input wire logic CORE_POWER,
  input wire logic CAL_BUSY,
  input wire logic CONV_BUSY,
  input wire logic [15:0] DATA,
  input wire acs_flags_t FLAGS,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  a_cal_blocks: assert property (CAL_BUSY |-> !CORE_START)
    else $error("core start during calibration");
  a_cal_factor: assert property (CAL_BUSY && CORE_DONE |=>
    !CAL_BUSY && DATA[6:0] == $past(CORE_CAL_FACTOR)) else $error("calibration end wrong");
  a_conv_flag: assert property (CONV_BUSY && !CAL_BUSY && CORE_DONE && !CONV_STOP
    |=> FLAGS.conv_done_flag) else $error("done flag not set");
  a_irq_map: assert property (IRQ == |(6'(FLAGS) & 6'($past(IEN))))
    else $error("interrupt not flag and enable");
  a_auto_off: assert property ((CFG.auto_off && !CONV_BUSY && !CAL_BUSY) [*2]
    |-> !CORE_POWER) else $error("core powered while idle");
  a_wake_power: assert property ($rose(CONV_BUSY) && !CAL_BUSY |-> ##[0:1] CORE_POWER)
    else $error("core not powered at start");
  a_chan_legal: assert property (CORE_START |-> CORE_CHANNEL < 19 && SEQ_MASK[CORE_CHANNEL])
    else $error("channel outside sequence");
  a_disc_single: assert property (CFG.discontinuous_en && !CFG.continuous_select
    && CORE_DONE && CONV_BUSY && !CAL_BUSY |-> ##[1:2] !CONV_BUSY) else $error("extra channel");
  c_overrun: cover property (FLAGS.overrun_flag);
  c_cal: cover property (CAL_BUSY && CORE_DONE);
  c_disc: cover property (CFG.discontinuous_en && CORE_START);
endmodule // acs_sva

/* File: tb/acs_core_model.sv */
// Behavioural model of the analog converter core
module acs_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwr,
  input wire logic start,
  input wire logic cal,
  input wire logic [3:0] dly,
  input wire logic [4:0] chan,
  output logic ready,
  output logic smp,
  output logic done,
  output logic [11:0] res,
  output logic [6:0] calf
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic busy;
  logic [4:0] ch_q;
  logic [11:0] nz;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {ready, smp, done, busy, cnt, ch_q, nz} <= 25'h0;
    end else begin
      ready <= pwr;
      smp <= busy && cnt == 4'h1;
      done <= busy && cnt == 4'h0;
      nz <= nz + 12'h9A5;
      if (start || cal) begin
        {busy, cnt, ch_q} <= {1'b1, dly, chan};
      end else if (busy) begin
        {busy, cnt} <= {cnt != 4'h0, cnt - 4'h1};
      end
    end
  end
  // Outputs churn outside the result cycle
  assign res = done ? {ch_q, 7'h2B} : nz;
  assign calf = done ? 7'h35 : nz[6:0];
endmodule // acs_core_model

/* File: tb/acs_sequencer_tb_top.sv */
// Self-checking bench of the conversion sequencer
`include "acs_consts.svh"
module acs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  logic clk, rst_n, en, cal, st, stp, rd, ready, smp, done, pwr, cst, ccal, cbusy, vbusy, irq;
  logic wd;
  logic [1:0] rsl;
  logic [18:0] mask;
  logic [7:0] trg;
  logic [11:0] res;
  logic [6:0] calf;
  logic [4:0] ch, last;
  logic [3:0] dly;
  logic [15:0] data;
  acs_cfg_t cfg;
  acs_ien_t ien;
  acs_flags_t fclr, flags;
  int miscompares, n_checks, nstart, i, m, k, n;
  acs_sequencer u_acs_sequencer (.SYS_CLK(clk), .ARST_N(rst_n), .CONVERTER_ENABLE(en),
    .CAL_START(cal), .CONV_START(st), .CONV_STOP(stp), .CFG(cfg), .IEN(ien), .SEQ_MASK(mask),
    .FLAG_CLR(fclr), .DATA_READ(rd), .TRIG_IN(trg), .CORE_READY(ready), .CORE_SMP_DONE(smp),
    .CORE_DONE(done), .CORE_RESULT(res), .CORE_CAL_FACTOR(calf), .CORE_WATCHDOG(wd),
    .CORE_POWER(pwr), .CORE_START(cst), .CORE_CAL(ccal), .CORE_CHANNEL(ch),
    .CORE_RESOLUTION(rsl), .CAL_BUSY(cbusy), .CONV_BUSY(vbusy), .DATA(data), .FLAGS(flags),
    .IRQ(irq));
  acs_core_model u_acs_core_model (.clk(clk), .rst_n(rst_n), .pwr(pwr), .start(cst), .cal(ccal),
    .dly(dly), .chan(ch), .ready(ready), .smp(smp), .done(done), .res(res), .calf(calf));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Next sequence channel above fr, wrapping to the lowest
  function automatic logic [4:0] nx(logic [18:0] mk, logic [4:0] fr);
    logic [4:0] lo, hi;
    {lo, hi} = 10'h3FF;
    for (int j = 18; j >= 0; j--) if (mk[j]) begin
      lo = 5'(j);
      if (j > fr) hi = 5'(j);
    end
    return (hi != 5'h1F) ? hi : lo;
  endfunction
  function automatic logic [15:0] ed(logic [4:0] c, logic [1:0] r, logic l);
    logic [11:0] v;
    v = {c, 7'h2B};
    return l ? {v, 4'h0} : {4'h0, v >> (2 * r)};
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cyc(int c);
    repeat (c) @(posedge clk);
  endtask
  task wait_n(int t);
    int w;
    w = 0;
    do begin
      @(posedge clk);
      #1;
      w++;
    end while ((nstart < t || cbusy !== 1'b0 || (vbusy !== 1'b0 && !cfg.continuous_select))
      && w < 3000);
    if (w >= 3000) begin
      miscompares++;
      final_report;
    end
  endtask
  task clr;
    @(posedge clk) fclr <= 6'h3F;
    @(posedge clk) fclr <= 6'h00;
  endtask
  always @(posedge clk) if (cst === 1'b1) begin
    chk("channel", {11'h0, nx(mask, last)}, {11'h0, ch});
    last = nx(mask, last);
    nstart++;
  end
  initial begin
    {en, cal, st, stp, rd, trg, mask, fclr, ien, cfg} = 56'h0;
    {rst_n, dly, last, miscompares, n_checks, nstart} = {1'b0, 4'h3, 5'h1F, 96'h0};
    wd = 1'b0;
    k = $urandom(95);
    cyc(12);
    rst_n <= 1'b1;
    @(posedge clk) cal <= 1'b1;
    @(posedge clk) cal <= 1'b0;
    wait_n(0);
    chk("cal factor", 16'h0035, {9'h0, data[6:0]});
    chk("cal busy", 16'h0000, {15'h0, cbusy});
    $display("test calibration done");
    for (i = 0; i < 4; i++) begin
      @(posedge clk) en <= 1'b1;
      mask <= (i == 3) ? 19'h00009 : 19'($urandom_range(1, 19'h7FFFF));
      cfg <= '{1'b0, 1'b0, i == 0, 2'(i), 1'($urandom), i != 3, 3'h0, 2'h0};
      ien <= acs_ien_t'(6'($urandom));
      dly <= 4'($urandom_range(1, 9));
      clr;
      {last, nstart} = {5'h1F, 32'h0};
      @(posedge clk) st <= 1'b1;
      @(posedge clk) st <= 1'b0;
      wait_n($countones(mask));
      k = nstart;
      chk("data", ed(i == 3 ? 5'h00 : last, 2'(i), i == 0), data);
      chk("resolution", {14'h0, 2'(i)}, {14'h0, rsl});
      chk("overrun", {15'h0, nstart > 1}, {15'h0, flags.overrun_flag});
      chk("done flag", 16'h0001, {15'h0, flags.conv_done_flag});
      chk("seq flag", 16'h0001, {15'h0, flags.seq_done_flag});
      cyc(30);
      chk("passes", 16'(k), 16'(nstart));
      $display("test single %0d done", i);
    end
    @(posedge clk) mask <= 19'h40022;
    last = 5'h1F;
    for (m = 0; m < 4; m++) begin
      @(posedge clk) cfg <= '{1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b1, `ACS_EXT_PIN_SEL, 2'(m)};
      clr;
      {n, nstart} = 64'h0;
      for (k = 0; k < 6; k++) begin
        @(posedge clk) trg[7] <= ~trg[7];
        n += (k % 2 == 0) ? m % 2 : m / 2;
        cyc(8);
        wait_n(n);
        chk("disc starts", 16'(n), 16'(nstart));
        chk("disc seq", {15'h0, n >= 3}, {15'h0, flags.seq_done_flag});
      end
      $display("test edge mode %0d done", m);
    end
    @(posedge clk) mask <= 19'($urandom_range(1, 19'h7FFFF));
    cfg <= '{1'b1, 1'b0, 1'b0, 2'h1, 1'b1, 1'b1, 3'h2, 2'h1};
    {last, nstart} = {5'h1F, 32'h0};
    @(posedge clk) trg[2] <= 1'b1;
    wait_n(2 * $countones(mask));
    chk("repeat", 16'h0001, {15'h0, nstart >= 2 * $countones(mask)});
    @(posedge clk) stp <= 1'b1;
    @(posedge clk) stp <= 1'b0;
    cyc(4);
    k = nstart;
    cyc(20);
    chk("stopped", 16'(k), 16'(nstart));
    $display("test continuous done");
    @(posedge clk) wd <= 1'b1;
    @(posedge clk) wd <= 1'b0;
    cyc(2);
    chk("watchdog", 16'h0001, {15'h0, flags.watchdog_flag});
    $display("test watchdog done");
    final_report;
  end
endmodule // acs_sequencer_tb_top
bind acs_sequencer acs_sva u_acs_sva (.SYS_CLK, .ARST_N, .CONV_STOP, .CFG, .IEN, .SEQ_MASK,
  .CORE_DONE, .CORE_CAL_FACTOR, .CORE_START, .CORE_CHANNEL, .CORE_POWER, .CAL_BUSY, .CONV_BUSY,
  .DATA, .FLAGS, .IRQ);
